// ===== hss_ctrl.sv
// What this block does
// - Command 24h latches parameter word into mode
// - Clear pulse high when D3 zero, else low
// - Clear pulse width chosen by D6..D4
// - Inter-step wait only when D7 set
// - Wait length chosen by D10..D8
// - D1 clears real position at end
// - D2 clears logical position at end
// - D0: step 3 stops on Z with home
// - Command 5Ah starts the search
// - Stop commands abort and end search
// - Stop during wait abandons the wait
// - Busy set at start, cleared after step 4
// - Errors set error bit and cause bits
// - Execution state number readable in D14..D9
// - States 0, 3, 6 for idle, step 1, wait
// - Irregular step 2: reverse, release, wait, forward
// - Wait states cover timer and clear pulse
// - State 28 Z search, 36 offset drive
// - Clear pulse at step 2/3 detection edge
// - One enable and interval for all waits
// - Alarm or emergency stops instantly with error
`timescale 1ns/1ps
`default_nettype none
`include "hss_params.svh"
module hss_ctrl
    import hss_pkg::*;
#(
    parameter logic [191:0] PULSE_CYC = `HSS_PULSE_TABLE,
    parameter logic [191:0] WAIT_CYC = `HSS_WAIT_TABLE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensors, already qualified to active high
    input wire logic step1DetectIn,
    input wire logic step2DetectIn,
    input wire logic homeSensorIn,
    input wire logic encoderZphaseIn,
    input wire logic limitHitIn,
    input wire logic alarmIn,
    input wire logic emergencyIn,
    input wire logic offsetDoneIn,
    // Drive control
    output logic searchDriveOut,
    output logic searchReverseOut,
    output logic lowSearchSpeed,
    output logic offsetDriveOut,
    output logic instantStopOut,
    output logic realPosClearOut,
    output logic logicalPosClearOut,
    output logic deviationClearOut
);
    // ==========================================
    // APB register access
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [15:0] parameterWrite_reg;
    logic [15:0] mode_reg;
    logic [1:0] cfg_reg;
    logic [6:0] errCause_reg;
    logic busy_reg;
    logic [5:0] exec_reg;
    hss_state_t state_reg, stateNext;

    wire setupPhase = psel && !penable;
    wire wrEn = psel && penable && pwrite && pready_reg;
    wire cmdWrite = wrEn && (paddr == `HSS_OFF_CMD);
    wire [7:0] cmdCode = pwdata[7:0];
    wire modeCmd = cmdWrite && (cmdCode == `HSS_CMD_MODE2);
    wire startCmd = cmdWrite && (cmdCode == `HSS_CMD_START);
    wire istopCmd = cmdWrite && (cmdCode == `HSS_CMD_ISTOP);
    wire stopCmd = istopCmd || (cmdWrite && (cmdCode == `HSS_CMD_DSTOP));
    wire paramWrite = wrEn && (paddr == `HSS_OFF_PARAM);
    wire cfgWrite = wrEn && (paddr == `HSS_OFF_CFG);
    wire errorBit = |errCause_reg;

    wire mapped = (paddr == `HSS_OFF_PARAM) || (paddr == `HSS_OFF_CMD)
        || (paddr == `HSS_OFF_MAIN) || (paddr == `HSS_OFF_ERR)
        || (paddr == `HSS_OFF_EXEC) || (paddr == `HSS_OFF_MODE)
        || (paddr == `HSS_OFF_CFG);

    wire [31:0] readMux =
        (paddr == `HSS_OFF_MAIN) ? {30'h00000000, errorBit, busy_reg} :
        (paddr == `HSS_OFF_ERR) ? {25'h0000000, errCause_reg} :
        (paddr == `HSS_OFF_EXEC) ? {17'h00000, exec_reg, 9'h000} :
        (paddr == `HSS_OFF_MODE) ? {16'h0000, mode_reg} :
        (paddr == `HSS_OFF_CFG) ? {30'h00000000, cfg_reg} :
        32'h00000000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (setupPhase) begin
                prdata_reg <= readMux;
                pslverr_reg <= !mapped;
            end
        end
    end

    // Mode only changes on the mode command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            parameterWrite_reg <= `HSS_PARAM_RST;
            mode_reg <= `HSS_MODE_RST;
            cfg_reg <= `HSS_CFG_RST;
        end else begin
            if (paramWrite) begin
                parameterWrite_reg <= pwdata[15:0];
            end
            if (modeCmd) begin
                mode_reg <= {5'h00, parameterWrite_reg[10:0]};
            end
            if (cfgWrite) begin
                cfg_reg <= pwdata[1:0];
            end
        end
    end

    // ==========================================
    // Mode fields
    wire andStop = mode_reg[`HSS_B_HOME_AND_ZPHASE_STOP];
    wire stepWaitEnable = mode_reg[`HSS_B_STEP_WAIT_ENABLE];
    wire clearPulseLow = mode_reg[`HSS_B_CLEAR_PULSE_POLARITY];
    wire [2:0] pulseSel = mode_reg[`HSS_F_DCP];
    wire [2:0] waitSel = mode_reg[`HSS_F_HTM];

    // ==========================================
    // Timers
    hss_tmr_if waitIf();
    hss_tmr_if pulseIf();
    logic tmrStart_reg, plsStart_reg, plsLag_reg;
    logic finish;

    assign waitIf.start = tmrStart_reg;
    assign waitIf.abort = finish;
    assign waitIf.cycles = hss_pick(WAIT_CYC, waitSel);
    assign pulseIf.start = plsStart_reg;
    assign pulseIf.abort = finish;
    assign pulseIf.cycles = hss_pick(PULSE_CYC, pulseSel);

    hss_wait_timer stepTimer (
        .clk(clk),
        .rstn(rstn),
        .tmr(waitIf)
    );

    hss_clear_pulse clearPulse (
        .clk(clk),
        .rstn(rstn),
        .tmr(pulseIf),
        .lowActive(clearPulseLow),
        .pulseOut(deviationClearOut)
    );

    // Leave a wait only when timer and pulse are both over
    wire waitDone = !tmrStart_reg && !plsStart_reg && !waitIf.busy
        && !pulseIf.busy && !plsLag_reg;

    // ==========================================
    // Sequencer
    logic step2Prev_reg, zPrev_reg;
    logic enterWait, fireClear, normalEnd, hardStop;
    logic [6:0] errSet;
    wire step2Rise = step2DetectIn && !step2Prev_reg;
    wire zRise = encoderZphaseIn && !zPrev_reg;
    wire active = (state_reg != HSS_IDLE);
    wire reverse = (state_reg == HSS_S2_REV_ON)
        || (state_reg == HSS_S2_REV_OFF);

    always_comb begin
        stateNext = state_reg;
        enterWait = 1'b0;
        fireClear = 1'b0;
        errSet = 7'h00;
        finish = 1'b0;
        normalEnd = 1'b0;
        hardStop = 1'b0;
        if (active && (alarmIn || emergencyIn)) begin
            errSet[`HSS_E_ALM] = alarmIn;
            errSet[`HSS_E_EMG] = emergencyIn;
            finish = 1'b1;
            hardStop = 1'b1;
        end else if (active && stopCmd) begin
            finish = 1'b1;
            hardStop = istopCmd;
        end else begin
            unique case (state_reg)
                HSS_IDLE: begin
                    if (startCmd) begin
                        stateNext = HSS_S1_SEARCH;
                    end
                end
                HSS_S1_SEARCH: begin
                    if (step1DetectIn || limitHitIn) begin
                        stateNext = HSS_S1_WAIT;
                        enterWait = 1'b1;
                    end
                end
                HSS_S1_WAIT: begin
                    if (waitDone) begin
                        stateNext = HSS_S2_SEARCH;
                    end
                end
                HSS_S2_SEARCH: begin
                    if (step2Rise) begin
                        stateNext = HSS_S2_WAIT;
                        enterWait = 1'b1;
                        fireClear = cfg_reg[`HSS_B_CFG_S2DC];
                    end else if (limitHitIn) begin
                        stateNext = HSS_S2_REV_ON;
                    end
                end
                HSS_S2_REV_ON: begin
                    if (step2DetectIn) begin
                        stateNext = HSS_S2_REV_OFF;
                    end else if (limitHitIn) begin
                        errSet[`HSS_E_LIMM] = 1'b1;
                        finish = 1'b1;
                    end
                end
                HSS_S2_REV_OFF: begin
                    if (!step2DetectIn) begin
                        stateNext = HSS_S2_REV_WAIT;
                        enterWait = 1'b1;
                    end else if (limitHitIn) begin
                        errSet[`HSS_E_LIMM] = 1'b1;
                        finish = 1'b1;
                    end
                end
                HSS_S2_REV_WAIT: begin
                    if (waitDone) begin
                        stateNext = HSS_S2_SEARCH;
                    end
                end
                HSS_S2_WAIT: begin
                    if (waitDone && encoderZphaseIn) begin
                        errSet[`HSS_E_ZACT] = 1'b1;
                        finish = 1'b1;
                    end else if (waitDone) begin
                        stateNext = HSS_S3_SEARCH;
                    end
                end
                HSS_S3_SEARCH: begin
                    if (zRise && (!andStop || homeSensorIn)) begin
                        stateNext = HSS_S3_WAIT;
                        enterWait = 1'b1;
                        fireClear = cfg_reg[`HSS_B_CFG_S3DC];
                    end else if (limitHitIn) begin
                        errSet[`HSS_E_LIMP] = 1'b1;
                        finish = 1'b1;
                    end
                end
                HSS_S3_WAIT: begin
                    if (waitDone) begin
                        stateNext = HSS_S4_OFFSET;
                    end
                end
                HSS_S4_OFFSET: begin
                    if (offsetDoneIn) begin
                        finish = 1'b1;
                        normalEnd = 1'b1;
                    end else if (limitHitIn) begin
                        errSet[`HSS_E_LIMP] = 1'b1;
                        finish = 1'b1;
                    end
                end
                default: begin
                    finish = 1'b1;
                end
            endcase
        end
        if (finish) begin
            stateNext = HSS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= HSS_IDLE;
            step2Prev_reg <= 1'b0;
            zPrev_reg <= 1'b0;
            tmrStart_reg <= 1'b0;
            plsStart_reg <= 1'b0;
            plsLag_reg <= 1'b0;
        end else begin
            state_reg <= stateNext;
            step2Prev_reg <= step2DetectIn;
            zPrev_reg <= encoderZphaseIn;
            tmrStart_reg <= enterWait && stepWaitEnable;
            plsStart_reg <= fireClear;
            plsLag_reg <= pulseIf.busy;
        end
    end

    // ==========================================
    // Status and outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            exec_reg <= `HSS_X_IDLE;
            errCause_reg <= 7'h00;
        end else begin
            busy_reg <= (stateNext != HSS_IDLE);
            exec_reg <= hss_exec_code(stateNext);
            if (startCmd && !active) begin
                errCause_reg <= 7'h00;
            end else begin
                errCause_reg <= errCause_reg | errSet;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            searchDriveOut <= 1'b0;
            searchReverseOut <= 1'b0;
            lowSearchSpeed <= 1'b0;
            offsetDriveOut <= 1'b0;
            instantStopOut <= 1'b0;
            realPosClearOut <= 1'b0;
            logicalPosClearOut <= 1'b0;
        end else begin
            searchDriveOut <= (stateNext == HSS_S1_SEARCH)
                || (stateNext == HSS_S2_SEARCH)
                || (stateNext == HSS_S2_REV_ON)
                || (stateNext == HSS_S2_REV_OFF)
                || (stateNext == HSS_S3_SEARCH);
            searchReverseOut <= (stateNext == HSS_S2_REV_ON)
                || (stateNext == HSS_S2_REV_OFF);
            lowSearchSpeed <= (stateNext == HSS_S2_SEARCH)
                || (stateNext == HSS_S3_SEARCH);
            offsetDriveOut <= (stateNext == HSS_S4_OFFSET);
            instantStopOut <= hardStop;
            realPosClearOut <= normalEnd
                && mode_reg[`HSS_B_REAL_POS_CLEAR_AT_END];
            logicalPosClearOut <= normalEnd
                && mode_reg[`HSS_B_LOGICAL_POS_CLEAR_AT_END];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ==========================================
    // Checks
    sequence s_mode_cmd;
        modeCmd;
    endsequence

    sequence s_start;
        startCmd && !active;
    endsequence

    a_mode_latch: assert property (@(posedge clk) disable iff (!rstn)
        s_mode_cmd |=> mode_reg[10:0] == $past(parameterWrite_reg[10:0]))
        else $error("mode not taken from parameter word");
    a_param_only: assert property (@(posedge clk) disable iff (!rstn)
        paramWrite |=> $stable(mode_reg))
        else $error("parameter write changed mode");
    a_start_busy: assert property (@(posedge clk) disable iff (!rstn)
        s_start |=> busy_reg && exec_reg == `HSS_X_S1)
        else $error("start did not raise busy");
    a_stop_ends: assert property (@(posedge clk) disable iff (!rstn)
        active && stopCmd |=> !busy_reg && exec_reg == `HSS_X_IDLE)
        else $error("stop did not end search");
    a_wait_abort: assert property (@(posedge clk) disable iff (!rstn)
        waitIf.busy && stopCmd |=> !waitIf.busy)
        else $error("wait not abandoned on stop");
    a_no_wait: assert property (@(posedge clk) disable iff (!rstn)
        enterWait && !stepWaitEnable |=> !tmrStart_reg ##1 !waitIf.busy)
        else $error("wait ran while disabled");
    a_and_stop: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == HSS_S3_SEARCH && andStop && !homeSensorIn
        && !limitHitIn && !alarmIn && !emergencyIn && !stopCmd
        |=> state_reg == HSS_S3_SEARCH)
        else $error("Z stop without home");
    a_alarm_err: assert property (@(posedge clk) disable iff (!rstn)
        active && alarmIn |=> errCause_reg[`HSS_E_ALM] && !busy_reg
        && instantStopOut)
        else $error("alarm not flagged");
    a_end_clear: assert property (@(posedge clk) disable iff (!rstn)
        normalEnd |=> realPosClearOut == mode_reg[`HSS_B_REAL_POS_CLEAR_AT_END]
        && logicalPosClearOut == mode_reg[`HSS_B_LOGICAL_POS_CLEAR_AT_END])
        else $error("end clear mismatch");
endmodule
`default_nettype wire

// ===== hss_params.svh
`ifndef HSS_PARAMS_SVH
`define HSS_PARAMS_SVH

// ==========================================
// Register byte offsets
`define HSS_OFF_PARAM 8'h00
`define HSS_OFF_CMD 8'h04
`define HSS_OFF_MAIN 8'h08
`define HSS_OFF_ERR 8'h0C
`define HSS_OFF_EXEC 8'h10
`define HSS_OFF_MODE 8'h14
`define HSS_OFF_CFG 8'h18

// ==========================================
// Reset values
`define HSS_PARAM_RST 16'h0000
`define HSS_MODE_RST 16'h0000
`define HSS_CFG_RST 2'h0

// ==========================================
// Command codes
`define HSS_CMD_MODE2 8'h24
`define HSS_CMD_START 8'h5A
`define HSS_CMD_DSTOP 8'h56
`define HSS_CMD_ISTOP 8'h57

// ==========================================
// Mode word two fields
`define HSS_B_HOME_AND_ZPHASE_STOP 0
`define HSS_B_REAL_POS_CLEAR_AT_END 1
`define HSS_B_LOGICAL_POS_CLEAR_AT_END 2
`define HSS_B_CLEAR_PULSE_POLARITY 3
`define HSS_F_DCP 6:4
`define HSS_B_STEP_WAIT_ENABLE 7
`define HSS_F_HTM 10:8

// ==========================================
// Status and config fields
`define HSS_B_BUSY 0
`define HSS_B_ERROR 1
`define HSS_EXEC_LSB 9
`define HSS_E_LIMP 2
`define HSS_E_LIMM 3
`define HSS_E_ALM 4
`define HSS_E_EMG 5
`define HSS_E_ZACT 6
`define HSS_B_CFG_S2DC 0
`define HSS_B_CFG_S3DC 1

// ==========================================
// Execution state numbers
`define HSS_X_IDLE 6'h00
`define HSS_X_S1 6'h03
`define HSS_X_W12 6'h06
`define HSS_X_REVON 6'h0B
`define HSS_X_REVOFF 6'h0F
`define HSS_X_REVW 6'h12
`define HSS_X_S2 6'h14
`define HSS_X_W23 6'h17
`define HSS_X_S3 6'h1C
`define HSS_X_W34 6'h20
`define HSS_X_S4 6'h24

// ==========================================
// Timing, counted at the reference clock
`define HSS_REF_MHZ 16
`define HSS_US_CYC(us) ((us) * `HSS_REF_MHZ)
`define HSS_MS_CYC(ms) ((ms) * 1000 * `HSS_REF_MHZ)
`define HSS_PULSE_TABLE {24'(`HSS_MS_CYC(20)), 24'(`HSS_MS_CYC(10)), \
    24'(`HSS_MS_CYC(2)), 24'(`HSS_MS_CYC(1)), 24'(`HSS_US_CYC(200)), \
    24'(`HSS_US_CYC(100)), 24'(`HSS_US_CYC(20)), 24'(`HSS_US_CYC(10))}
`define HSS_WAIT_TABLE {24'(`HSS_MS_CYC(1000)), 24'(`HSS_MS_CYC(500)), \
    24'(`HSS_MS_CYC(200)), 24'(`HSS_MS_CYC(100)), 24'(`HSS_MS_CYC(20)), \
    24'(`HSS_MS_CYC(10)), 24'(`HSS_MS_CYC(2)), 24'(`HSS_MS_CYC(1))}

`endif

// ===== hss_pkg.sv
`default_nettype none
package hss_pkg;

`include "hss_params.svh"

typedef enum logic [3:0] {
    HSS_IDLE, HSS_S1_SEARCH, HSS_S1_WAIT, HSS_S2_REV_ON, HSS_S2_REV_OFF,
    HSS_S2_REV_WAIT, HSS_S2_SEARCH, HSS_S2_WAIT, HSS_S3_SEARCH,
    HSS_S3_WAIT, HSS_S4_OFFSET
} hss_state_t;

typedef logic [23:0] hss_cyc_t;

function automatic logic [5:0] hss_exec_code(hss_state_t s);
    unique case (s)
        HSS_IDLE: return `HSS_X_IDLE;
        HSS_S1_SEARCH: return `HSS_X_S1;
        HSS_S1_WAIT: return `HSS_X_W12;
        HSS_S2_REV_ON: return `HSS_X_REVON;
        HSS_S2_REV_OFF: return `HSS_X_REVOFF;
        HSS_S2_REV_WAIT: return `HSS_X_REVW;
        HSS_S2_SEARCH: return `HSS_X_S2;
        HSS_S2_WAIT: return `HSS_X_W23;
        HSS_S3_SEARCH: return `HSS_X_S3;
        HSS_S3_WAIT: return `HSS_X_W34;
        HSS_S4_OFFSET: return `HSS_X_S4;
        default: return `HSS_X_IDLE;
    endcase
endfunction

function automatic hss_cyc_t hss_pick(logic [191:0] tbl, logic [2:0] sel);
    return tbl[24 * sel +: 24];
endfunction

endpackage
`default_nettype wire

// ===== hss_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hss_tmr_if;
    logic start;
    logic abort;
    logic [23:0] cycles;
    logic busy;
    modport ctrl(output start, output abort, output cycles, input busy);
    modport unit(input start, input abort, input cycles, output busy);
endinterface
`default_nettype wire

// ===== hss_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module hss_wait_timer
    import hss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    hss_tmr_if.unit tmr
);
    logic [23:0] count_reg;
    logic busy_reg;
    wire lastTick = busy_reg && (count_reg == 24'h000001);

    // Busy for exactly the loaded number of cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= 24'h000000;
            busy_reg <= 1'b0;
        end else if (tmr.abort) begin
            count_reg <= 24'h000000;
            busy_reg <= 1'b0;
        end else if (tmr.start) begin
            count_reg <= tmr.cycles;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            count_reg <= count_reg - 24'h000001;
            busy_reg <= !lastTick;
        end
    end

    assign tmr.busy = busy_reg;

    a_timer_width: assert property (@(posedge clk) disable iff (!rstn)
        tmr.start && !tmr.abort && tmr.cycles == 24'h000002
        |=> busy_reg ##1 busy_reg ##1 !busy_reg)
        else $error("timer width differs from loaded count");
endmodule
`default_nettype wire

// ===== hss_clear_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module hss_clear_pulse
    import hss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Width timer control
    hss_tmr_if.unit tmr,
    // Polarity and pin
    input wire logic lowActive,
    output logic pulseOut
);
    logic pulse_reg;

    hss_wait_timer widthTimer (
        .clk(clk),
        .rstn(rstn),
        .tmr(tmr)
    );

    // Idle level is the inverse of the active level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= tmr.busy ? !lowActive : lowActive;
        end
    end

    assign pulseOut = pulse_reg;

    a_pulse_level: assert property (@(posedge clk) disable iff (!rstn)
        $past(tmr.busy) |-> pulseOut == !$past(lowActive))
        else $error("clear pulse at wrong level");
endmodule
`default_nettype wire

// ===== hss_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module hss_axis_model #(
    parameter int DLY = 8
) (
    // Clock
    input wire logic clk,
    // Drive from the block
    input wire logic searchDriveOut,
    input wire logic offsetDriveOut,
    // Sensors back to the block
    output logic detect,
    output logic offsetDoneIn
);
    int cnt = 0;
    initial offsetDoneIn = 1'b0;
    // ==========================================
    // Detect goes active DLY cycles into a search, drops when it stops; offset done follows offset drive one cycle later
    always @(posedge clk) begin
        cnt <= searchDriveOut ? cnt + 1 : 0;
        offsetDoneIn <= offsetDriveOut;
    end
    // Home and Z rise together, so the AND stop is met
    assign detect = (cnt >= DLY);
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hss_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic alarmIn = 1'b0;
    logic limitIn = 1'b0;
    logic rev;
    int revCnt = 0;
    logic idleLvl = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, det, offDone;
    logic drv, offDrv, iStop, real_pos_clear_at_end, logical_pos_clear_at_end, dcc;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int lowCnt = 0;
    int clrCnt = 0;
    int stopCnt = 0;

    function automatic logic [191:0] tbl(int b);
        for (int i = 0; i < 8; i++) tbl[24*i +: 24] = 24'(b + i);
    endfunction

    hss_ctrl #(.PULSE_CYC(tbl(3)), .WAIT_CYC(tbl(5))) dut (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .step1DetectIn(det), .step2DetectIn(det), .homeSensorIn(det),
        .encoderZphaseIn(det), .limitHitIn(limitIn), .alarmIn(alarmIn),
        .emergencyIn(1'b0), .offsetDoneIn(offDone),
        .searchDriveOut(drv), .searchReverseOut(rev), .lowSearchSpeed(),
        .offsetDriveOut(offDrv), .instantStopOut(iStop),
        .realPosClearOut(real_pos_clear_at_end), .logicalPosClearOut(logical_pos_clear_at_end),
        .deviationClearOut(dcc));
    hss_axis_model #(.DLY(8)) axis (.clk(clk), .searchDriveOut(drv),
        .offsetDriveOut(offDrv), .detect(det), .offsetDoneIn(offDone));

    initial forever #20 clk = ~clk;

    // ==========================================
    // Monitors and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rstn && dcc !== idleLvl) lowCnt <= lowCnt + 1;
        clrCnt <= clrCnt + (real_pos_clear_at_end === 1'b1) + (logical_pos_clear_at_end === 1'b1);
        stopCnt <= stopCnt + (iStop === 1'b1);
        revCnt <= revCnt + (rev === 1'b1);
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    task finish_test;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // ==========================================
    // Bus cycles
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask

    task wait_state(input logic [31:0] exp);
        do apb(1'h0, 8'h10, 32'h0); while (rd !== exp);
    endtask

    // ==========================================
    // Scenarios
    task t_reset;
        rchk(8'h14, 32'h0);
        rchk(8'h08, 32'h0);
        rchk(8'h10, 32'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task t_mode;
        apb(1'h1, 8'h00, 32'h1AF);
        rchk(8'h14, 32'h0);
        apb(1'h1, 8'h04, 32'h24);
        rchk(8'h14, 32'h1AF);
        idleLvl = 1'b1;
    endtask

    task t_search;
        int l0;
        int c0;
        apb(1'h1, 8'h18, 32'h3);
        l0 = lowCnt;
        c0 = clrCnt;
        apb(1'h1, 8'h04, 32'h5A);
        rchk(8'h08, 32'h1);
        rchk(8'h10, 32'h600);
        wait_state(32'h0);
        chk(32'(lowCnt - l0), 32'hA);
        chk(32'(clrCnt - c0), 32'h2);
        rchk(8'h08, 32'h0);
    endtask

    task t_stop;
        int s0;
        int c0;
        apb(1'h1, 8'h00, 32'h7AF);
        apb(1'h1, 8'h04, 32'h24);
        apb(1'h1, 8'h04, 32'h5A);
        wait_state(32'hC00);
        s0 = stopCnt;
        c0 = clrCnt;
        apb(1'h1, 8'h04, 32'h57);
        rchk(8'h08, 32'h0);
        rchk(8'h10, 32'h0);
        chk(32'(stopCnt - s0), 32'h1);
        apb(1'h1, 8'h04, 32'h5A);
        apb(1'h1, 8'h04, 32'h56);
        rchk(8'h08, 32'h0);
        chk(32'(stopCnt - s0), 32'h1);
        chk(32'(clrCnt - c0), 32'h0);
    endtask

    task t_limit;
        int r0;
        r0 = revCnt;
        limitIn <= 1'b1;
        apb(1'h1, 8'h04, 32'h5A);
        wait_state(32'h0);
        limitIn <= 1'b0;
        chk(32'(revCnt - r0), 32'h1);
        rchk(8'h08, 32'h2);
        rchk(8'h0C, 32'h8);
    endtask

    task t_alarm;
        apb(1'h1, 8'h04, 32'h5A);
        alarmIn <= 1'b1;
        @(posedge clk);
        alarmIn <= 1'b0;
        rchk(8'h08, 32'h2);
        rchk(8'h0C, 32'h10);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_mode();
        t_search();
        t_stop();
        t_limit();
        t_alarm();
        finish_test();
    end
endmodule
`default_nettype wire
